/* hdl/lpm_ctrl.sv */
// low-power mode sequencer with clock supervision
`timescale 1ns/1ps

// What this block does
// - sleep halts only the core clock; peripherals keep running
// - any peripheral interrupt or event ends sleep at once
// - stop gates core clocks, disables pll and both fast oscillators
// - software picks normal or low-power regulator during stop
// - any external interrupt line source wakes from stop
// - cec, serial and two-wire ports may request the rc oscillator in stop
// - regulator returns to normal before the rc clock reaches a peripheral
// - standby turns off regulator, core domain, pll and both oscillators
// - standby loses core state; only rtc and standby logic survive
// - standby ends only on reset pin, watchdog, wake pin rise, rtc
// - rtc, watchdog and their clock sources run in stop and standby
// - after reset the core runs from the internal rc oscillator
// - failed external clock falls back to rc without software
// - clock-fail interrupt raised only when enabled
// - prescalers derive bus clocks, each limited to 48 MHz
module lpm_ctrl #(
  parameter int FAIL_WINDOW = lpm_pkg::FAIL_WINDOW_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic wfi_i,
  input wire logic deep_sleep_i,
  input wire logic standby_sel_i,
  input wire logic stop_low_power_reg_i,
  input wire logic periph_event_i,
  input wire lpm_pkg::lpm_stop_wake_type stop_wake_i,
  input wire lpm_pkg::lpm_standby_wake_type standby_wake_i,
  input wire logic [2:0] rc_request_i,
  input wire lpm_pkg::lpm_clk_src_type clk_src_sel_i,
  input wire logic ext_clk_edge_i,
  input wire logic fail_irq_en_i,
  input wire logic fail_clear_i,
  input wire logic [lpm_pkg::PRESC_WIDTH-1:0] ahb_div_i,
  input wire logic [lpm_pkg::PRESC_WIDTH-1:0] apb_div_i,
  output logic core_clk_en_o,
  output logic periph_clk_en_o,
  output logic [2:0] rc_grant_o,
  output lpm_pkg::lpm_power_ctrl_type power_o,
  output logic always_on_en_o,
  output logic retain_lost_o,
  output lpm_pkg::lpm_state_type state_o,
  output lpm_pkg::lpm_clk_src_type clk_src_o,
  output logic clk_fail_o,
  output logic clk_fail_irq_o,
  output logic ahb_tick_o,
  output logic apb_tick_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [lpm_pkg::PRESC_WIDTH-1:0] clamp_div(
    input logic [lpm_pkg::PRESC_WIDTH-1:0] div
  );
    localparam logic [lpm_pkg::PRESC_WIDTH-1:0] MIN_DIV =
      lpm_pkg::PRESC_WIDTH'(lpm_pkg::BUS_MIN_DIV - 1);
    clamp_div = (div < MIN_DIV) ? MIN_DIV : div;
  endfunction : clamp_div

  lpm_pkg::lpm_state_type state_q;
  lpm_pkg::lpm_state_type state_d;
  logic stop_wake;
  logic standby_wake;
  logic wake_pin_q;
  logic reg_low_q;
  logic [2:0] rc_grant_q;
  lpm_pkg::lpm_clk_src_type src_q;
  logic [lpm_pkg::FAIL_CNT_WIDTH-1:0] miss_cnt_q;
  logic fail_q;
  logic [lpm_pkg::PRESC_WIDTH-1:0] ahb_cnt_q;
  logic [lpm_pkg::PRESC_WIDTH-1:0] apb_cnt_q;

  assign stop_wake = |stop_wake_i;
  // wake pin counts only on its rising edge
  assign standby_wake = standby_wake_i.external_reset_pin |
    standby_wake_i.independent_watchdog | standby_wake_i.rtc |
    (standby_wake_i.wake_pin & ~wake_pin_q);

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      lpm_pkg::LPM_RUN: begin
        if (wfi_i) begin
          if (!deep_sleep_i) begin
            state_d = lpm_pkg::LPM_SLEEP;
          end else if (standby_sel_i) begin
            state_d = lpm_pkg::LPM_STANDBY;
          end else begin
            state_d = lpm_pkg::LPM_STOP;
          end
        end
      end
      lpm_pkg::LPM_SLEEP: begin
        if (periph_event_i || stop_wake) begin
          state_d = lpm_pkg::LPM_RUN;
        end
      end
      lpm_pkg::LPM_STOP: begin
        if (stop_wake) begin
          state_d = lpm_pkg::LPM_RUN;
        end
      end
      lpm_pkg::LPM_STANDBY: begin
        if (standby_wake) begin
          state_d = lpm_pkg::LPM_RUN;
        end
      end
      default: state_d = lpm_pkg::LPM_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= lpm_pkg::LPM_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wake_pin_q <= 1'b0;
    end else begin
      wake_pin_q <= standby_wake_i.wake_pin;
    end
  end

  // regulator mode is latched at stop entry; an rc request mid-stop returns it to normal
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_low_q <= 1'b0;
    end else if (state_q == lpm_pkg::LPM_STOP) begin
      if (|rc_request_i) begin
        reg_low_q <= 1'b0;
      end
    end else if (state_d == lpm_pkg::LPM_STOP) begin
      reg_low_q <= stop_low_power_reg_i;
    end else begin
      reg_low_q <= 1'b0;
    end
  end

  // grant waits one cycle behind regulator back to normal
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rc_grant_q <= 3'h0;
    end else if (state_q == lpm_pkg::LPM_STOP && !reg_low_q) begin
      rc_grant_q <= rc_request_i;
    end else begin
      rc_grant_q <= 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // clock source and failure supervision
  // ----------------------------------------------------------------
  // crystal is off in stop and standby, so missing edges there are no fault;
  // a crystal slower to restart than the window trips right after wake
  logic ext_watch;
  assign ext_watch = (src_q == lpm_pkg::LPM_SRC_EXT) &&
    (state_q == lpm_pkg::LPM_RUN || state_q == lpm_pkg::LPM_SLEEP);

  // counter width bounds the window; keep FAIL_WINDOW below 256
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      miss_cnt_q <= '0;
    end else if (!ext_watch || ext_clk_edge_i) begin
      miss_cnt_q <= '0;
    end else if (miss_cnt_q != FAIL_WINDOW[lpm_pkg::FAIL_CNT_WIDTH-1:0]) begin
      miss_cnt_q <= miss_cnt_q + 1'b1;
    end
  end

  logic fail_now;
  assign fail_now = ext_watch &&
    (miss_cnt_q == FAIL_WINDOW[lpm_pkg::FAIL_CNT_WIDTH-1:0]);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      src_q <= lpm_pkg::LPM_SRC_RC;
    end else if (fail_now) begin
      src_q <= lpm_pkg::LPM_SRC_RC;
    end else if (state_q == lpm_pkg::LPM_RUN && !fail_q) begin
      src_q <= clk_src_sel_i;
    end
  end

  // set wins over clear; fallback holds until software clears the flag
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fail_q <= 1'b0;
    end else if (fail_now) begin
      fail_q <= 1'b1;
    end else if (fail_clear_i) begin
      fail_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // bus prescalers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ahb_cnt_q <= '0;
    end else if (ahb_cnt_q >= clamp_div(ahb_div_i)) begin
      ahb_cnt_q <= '0;
    end else begin
      ahb_cnt_q <= ahb_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      apb_cnt_q <= '0;
    end else if (apb_cnt_q >= clamp_div(apb_div_i)) begin
      apb_cnt_q <= '0;
    end else begin
      apb_cnt_q <= apb_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic run_like;
  assign run_like = (state_q == lpm_pkg::LPM_RUN);
  assign core_clk_en_o = run_like;
  assign periph_clk_en_o = run_like ||
    state_q == lpm_pkg::LPM_SLEEP;
  assign rc_grant_o = rc_grant_q;
  assign always_on_en_o = 1'b1;
  assign retain_lost_o = (state_q == lpm_pkg::LPM_STANDBY);
  assign state_o = state_q;
  assign clk_src_o = src_q;
  assign clk_fail_o = fail_q;
  assign clk_fail_irq_o = fail_q & fail_irq_en_i;
  assign ahb_tick_o = (ahb_cnt_q == '0);
  assign apb_tick_o = (apb_cnt_q == '0);

  always_comb begin
    power_o = '0;
    power_o.core_domain_powered = 1'b1;
    power_o.regulator_on = 1'b1;
    power_o.internal_rc_osc = 1'b1;
    power_o.external_crystal_osc = (src_q == lpm_pkg::LPM_SRC_EXT);
    power_o.pll = (src_q == lpm_pkg::LPM_SRC_PLL);
    case (state_q)
      lpm_pkg::LPM_STOP: begin
        power_o.internal_rc_osc = |rc_grant_q;
        power_o.external_crystal_osc = 1'b0;
        power_o.pll = 1'b0;
        power_o.regulator_low_power = reg_low_q;
      end
      lpm_pkg::LPM_STANDBY: begin
        power_o.core_domain_powered = 1'b0;
        power_o.regulator_on = 1'b0;
        power_o.internal_rc_osc = 1'b0;
        power_o.external_crystal_osc = 1'b0;
        power_o.pll = 1'b0;
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence stop_req_s;
    state_q == lpm_pkg::LPM_STOP && reg_low_q && rc_request_i != 3'h0;
  endsequence

  sleep_core_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    state_q == lpm_pkg::LPM_SLEEP |-> !core_clk_en_o && periph_clk_en_o)
    else $error("sleep clocks wrong");
  sleep_wake_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    state_q == lpm_pkg::LPM_SLEEP && periph_event_i
    |=> state_q == lpm_pkg::LPM_RUN)
    else $error("sleep did not wake");
  stop_osc_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    state_q == lpm_pkg::LPM_STOP |-> !power_o.pll
    && !power_o.external_crystal_osc && !periph_clk_en_o)
    else $error("stop left clocks on");
  stop_wake_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    state_q == lpm_pkg::LPM_STOP && stop_wake
    |=> state_q == lpm_pkg::LPM_RUN)
    else $error("stop did not wake");
  reg_first_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    stop_req_s |-> rc_grant_o == 3'h0 ##1 !reg_low_q)
    else $error("clock before regulator");
  standby_off_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    state_q == lpm_pkg::LPM_STANDBY |-> !power_o.regulator_on
    && !power_o.core_domain_powered && retain_lost_o)
    else $error("standby power left on");
  standby_exit_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    $past(state_q) == lpm_pkg::LPM_STANDBY && state_q == lpm_pkg::LPM_RUN
    |-> $past(standby_wake))
    else $error("standby exit without source");
  fail_back_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    fail_now |=> clk_src_o == lpm_pkg::LPM_SRC_RC && clk_fail_o)
    else $error("no fallback on failure");
  fail_irq_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    clk_fail_irq_o |-> fail_irq_en_i && clk_fail_o)
    else $error("irq while disabled");
  wfi_mode_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    state_q == lpm_pkg::LPM_RUN && wfi_i && !deep_sleep_i
    |=> state_q == lpm_pkg::LPM_SLEEP)
    else $error("wrong mode on wfi");

endmodule : lpm_ctrl

/* hdl/lpm_pkg.sv */
// package for the low-power mode and clock-fail controller
package lpm_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int EXT_LINE_COUNT = 16;
  localparam int PRESC_WIDTH = 4;
  localparam int CLK_RATE_MHZ = 200;
  localparam int BUS_MAX_MHZ = 48;
  // least divide so a bus clock never passes its maximum
  localparam int BUS_MIN_DIV = (CLK_RATE_MHZ + BUS_MAX_MHZ - 1) / BUS_MAX_MHZ;
  // external clock watchdog: missing-edge window
  localparam int EXT_MIN_MHZ = 4;
  localparam int FAIL_WINDOW_NS = 1000 / EXT_MIN_MHZ * 2;
  localparam int FAIL_WINDOW_CYC = FAIL_WINDOW_NS * CLK_RATE_MHZ / 1000;
  localparam int FAIL_CNT_WIDTH = 8;

  // ----------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LPM_RUN = 2'b00,
    LPM_SLEEP = 2'b01,
    LPM_STOP = 2'b10,
    LPM_STANDBY = 2'b11
  } lpm_state_type;

  typedef enum logic [1:0] {
    LPM_SRC_RC = 2'b00,
    LPM_SRC_EXT = 2'b01,
    LPM_SRC_PLL = 2'b10
  } lpm_clk_src_type;

  // stop-mode wake sources
  typedef struct packed {
    logic [EXT_LINE_COUNT-1:0] ext_interrupt_lines;
    logic supply_voltage_detector;
    logic rtc;
    logic first_two_wire_port;
    logic first_serial_port;
    logic comparator_outputs;
    logic cec;
  } lpm_stop_wake_type;

  // standby exit sources
  typedef struct packed {
    logic external_reset_pin;
    logic independent_watchdog;
    logic wake_pin;
    logic rtc;
  } lpm_standby_wake_type;

  // oscillator and regulator enables
  typedef struct packed {
    logic internal_rc_osc;
    logic external_crystal_osc;
    logic pll;
    logic regulator_on;
    logic regulator_low_power;
    logic core_domain_powered;
  } lpm_power_ctrl_type;

endpackage : lpm_pkg

/* bench/lpm_tb_osc.sv */
// far-side model: external clock source feeding the edge detector
`timescale 1ns/1ps

// ----------------------------------------------------------------
// external oscillator model
// ----------------------------------------------------------------
module lpm_tb_osc (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic slow_i,
  output logic edge_o
);
  logic [3:0] cnt_q;
  // a dead crystal gives no edges at all, not a stuck pulse
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 4'h0;
      edge_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q <= 4'h0;
      edge_o <= 1'b0;
    end else begin
      cnt_q <= (cnt_q >= (slow_i ? 4'h6 : 4'h2)) ? 4'h0 : cnt_q + 4'h1;
      edge_o <= (cnt_q == 4'h0);
    end
  end
endmodule : lpm_tb_osc

/* bench/tb_top.sv */
// bench: stimulus, scoreboard and verdict for the low-power controller
`timescale 1ns/1ps
`define LPM_CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin \
  mismatches++; $display("Error %s expected %0h seen %0h", nm, e, s); end end

module tb_top;
  localparam int FW = 10;
  typedef struct {string nm; int sel; logic [31:0] e;} lpm_note_type;
  lpm_note_type notes[$];
  lpm_note_type n_q;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] meas = 32'h0;
  logic [31:0] rnd = 32'd73732;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wfi_i = 1'b0, deep_sleep_i = 1'b0, standby_sel_i = 1'b0;
  logic stop_low_power_reg_i = 1'b0, periph_event_i = 1'b0;
  lpm_pkg::lpm_stop_wake_type stop_wake_i = '0;
  lpm_pkg::lpm_standby_wake_type standby_wake_i = '0;
  logic [2:0] rc_request_i = 3'h0;
  lpm_pkg::lpm_clk_src_type clk_src_sel_i = lpm_pkg::LPM_SRC_RC;
  logic ext_clk_edge_i, fail_irq_en_i = 1'b0, fail_clear_i = 1'b0;
  logic osc_run = 1'b0, osc_slow = 1'b0;
  logic [3:0] ahb_div_i = 4'h0, apb_div_i = 4'h4;
  logic core_clk_en_o, periph_clk_en_o, always_on_en_o, retain_lost_o;
  logic clk_fail_o, clk_fail_irq_o, ahb_tick_o, apb_tick_o;
  logic [2:0] rc_grant_o;
  lpm_pkg::lpm_power_ctrl_type power_o;
  lpm_pkg::lpm_state_type state_o;
  lpm_pkg::lpm_clk_src_type clk_src_o;

  initial forever #2.5 sys_clk_i = ~sys_clk_i;

  lpm_ctrl #(.FAIL_WINDOW(FW)) i_lpm_ctrl (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .wfi_i(wfi_i), .deep_sleep_i(deep_sleep_i),
    .standby_sel_i(standby_sel_i), .stop_low_power_reg_i(stop_low_power_reg_i),
    .periph_event_i(periph_event_i), .stop_wake_i(stop_wake_i),
    .standby_wake_i(standby_wake_i), .rc_request_i(rc_request_i),
    .clk_src_sel_i(clk_src_sel_i), .ext_clk_edge_i(ext_clk_edge_i),
    .fail_irq_en_i(fail_irq_en_i), .fail_clear_i(fail_clear_i),
    .ahb_div_i(ahb_div_i), .apb_div_i(apb_div_i),
    .core_clk_en_o(core_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .rc_grant_o(rc_grant_o), .power_o(power_o),
    .always_on_en_o(always_on_en_o), .retain_lost_o(retain_lost_o),
    .state_o(state_o), .clk_src_o(clk_src_o), .clk_fail_o(clk_fail_o),
    .clk_fail_irq_o(clk_fail_irq_o), .ahb_tick_o(ahb_tick_o),
    .apb_tick_o(apb_tick_o));

  // crystal model only runs while the block enables it
  lpm_tb_osc i_lpm_tb_osc (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .run_i(osc_run & power_o.external_crystal_osc), .slow_i(osc_slow),
    .edge_o(ext_clk_edge_i));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] pick(input int sel);
    case (sel)
      0: pick = {30'h0, state_o};
      1: pick = {30'h0, core_clk_en_o, periph_clk_en_o};
      2: pick = {29'h0, rc_grant_o};
      3: pick = {26'h0, power_o};
      4: pick = {30'h0, retain_lost_o, always_on_en_o};
      5: pick = {30'h0, clk_src_o};
      6: pick = {30'h0, clk_fail_o, clk_fail_irq_o};
      7: pick = {31'h0, ahb_tick_o};
      8: pick = {31'h0, apb_tick_o};
      default: pick = meas;
    endcase
  endfunction : pick

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic note(input string nm, input int sel, input logic [31:0] e);
    notes.push_back('{nm, sel, e});
  endtask : note

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : cyc

  task automatic wait_for(input int sel, input logic [31:0] e, input int max);
    int i;
    for (i = 0; i < max && pick(sel) !== e; i++) cyc(1);
    if (pick(sel) !== e) begin
      mismatches++;
      $display("Error wait sel %0d expected %0h seen %0h", sel, e, pick(sel));
      report_and_stop();
    end
  endtask : wait_for

  task automatic period(input int sel, input logic [31:0] e);
    wait_for(sel, 32'h1, 40);
    cyc(1);
    meas = 32'h1;
    while (pick(sel) !== 32'h1 && meas < 32'h40) begin
      cyc(1);
      meas = meas + 32'h1;
    end
    note("tick period", 99, e);
  endtask : period

  task automatic report_and_stop();
    $display("counts: compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // watcher: outputs seen at the edge against every pending note
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    while (notes.size() > 0) begin
      n_q = notes.pop_front();
      `LPM_CHK(n_q.nm, n_q.e, pick(n_q.sel))
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    int b;
    cyc(20);
    reset_i = 1'b0;
    note("src", 5, 32'h0);
    note("power", 3, 32'h25);
    note("keep", 4, 32'h1);
    cyc(1);
    wfi_i = 1'b1;
    cyc(1);
    wfi_i = 1'b0;
    note("state", 0, 32'h1);
    note("clk en", 1, 32'h1);
    periph_event_i = 1'b1;
    cyc(1);
    periph_event_i = 1'b0;
    note("state", 0, 32'h0);
    $display("test sleep done");
    {wfi_i, deep_sleep_i, stop_low_power_reg_i} = 3'b111;
    cyc(1);
    wfi_i = 1'b0;
    note("state", 0, 32'h2);
    note("power", 3, 32'h07);
    note("keep", 4, 32'h1);
    rc_request_i = 3'h1;
    cyc(1);
    note("power", 3, 32'h05);
    note("grant", 2, 32'h0);
    cyc(1);
    note("grant", 2, 32'h1);
    note("power", 3, 32'h25);
    rnd = lfsr(rnd);
    stop_wake_i = 21'h1 << (rnd % 21);
    cyc(1);
    {stop_wake_i, rc_request_i} = '0;
    note("state", 0, 32'h0);
    $display("test stop done");
    {wfi_i, standby_sel_i} = 2'b11;
    cyc(1);
    wfi_i = 1'b0;
    stop_wake_i = '1;
    note("state", 0, 32'h3);
    note("power", 3, 32'h0);
    note("lost", 4, 32'h3);
    cyc(3);
    stop_wake_i = '0;
    note("state", 0, 32'h3);
    standby_wake_i.wake_pin = 1'b1;
    wait_for(0, 32'h0, 3);
    standby_wake_i.wake_pin = 1'b0;
    wfi_i = 1'b1;
    cyc(1);
    wfi_i = 1'b0;
    note("state", 0, 32'h3);
    rnd = lfsr(rnd);
    standby_wake_i = (rnd % 3 == 0) ? 4'h1 : (rnd % 3 == 1) ? 4'h4 : 4'h8;
    wait_for(0, 32'h0, 3);
    standby_wake_i = '0;
    {deep_sleep_i, standby_sel_i, stop_low_power_reg_i} = 3'b000;
    $display("test standby done");
    for (b = 0; b < 2; b++) begin
      fail_irq_en_i = ~b[0];
      osc_slow = b[0];
      osc_run = 1'b1;
      clk_src_sel_i = lpm_pkg::LPM_SRC_EXT;
      wait_for(5, 32'h1, 4);
      cyc(3 * FW);
      note("src", 5, 32'h1);
      osc_run = 1'b0;
      wait_for(6, {30'h0, 1'b1, ~b[0]}, FW + 4);
      note("src", 5, 32'h0);
      cyc(2);
      note("refused", 5, 32'h0);
      clk_src_sel_i = lpm_pkg::LPM_SRC_RC;
      fail_clear_i = 1'b1;
      cyc(1);
      fail_clear_i = 1'b0;
      note("fail", 6, 32'h0);
      cyc(1);
    end
    osc_run = 1'b1;
    clk_src_sel_i = lpm_pkg::LPM_SRC_PLL;
    cyc(2);
    note("pll", 3, 32'h2D);
    clk_src_sel_i = lpm_pkg::LPM_SRC_EXT;
    cyc(2);
    {wfi_i, deep_sleep_i, rc_request_i} = 5'h1C;
    cyc(1);
    wfi_i = 1'b0;
    note("state", 0, 32'h2);
    cyc(1);
    note("grant", 2, 32'h4);
    cyc(FW + 4);
    note("no fail in stop", 6, 32'h0);
    stop_wake_i.rtc = 1'b1;
    cyc(1);
    {stop_wake_i, rc_request_i, deep_sleep_i, osc_run} = '0;
    clk_src_sel_i = lpm_pkg::LPM_SRC_RC;
    note("state", 0, 32'h0);
    $display("test clock fail done");
    rnd = lfsr(rnd);
    apb_div_i = 4'h4 + 4'(rnd % 12);
    cyc(2);
    period(7, 32'(lpm_pkg::BUS_MIN_DIV));
    period(8, 32'(apb_div_i) + 32'h1);
    cyc(1);
    $display("test prescaler done");
    report_and_stop();
  end
endmodule : tb_top
